/* wcw_top.sv */
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wcw_cfg.svh"

module wcw_top
   import wcw_pkg::*;
#(
   parameter int unsigned LONG_TAP = `WCW_TAP_LONG
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        INT_RST_I,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [17:0] WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        STOP_REQ_I,
   input  wire logic        WAKE_I,
   input  wire logic        VEC_FETCH_I,
   input  wire logic        MON_MODE_I,
   input  wire logic        BREAK_I,
   input  wire logic        EXT_RST_N_I,
   input  wire logic        TST_IRQ_I,
   input  wire logic        TST_RST_I,
   output wcw_opt_t         OPT_O,
   output wcw_ctl_t         CTL_O,
   output logic             STOP_O,
   output logic             ILLEGAL_OP_O,
   output logic             WDOG_RST_N_O,
   output logic             RST_PIN_OE_N_O
);

   // ==========================================================
   // Helpers
   // Mask of the prescaler bits below a tap
   function automatic logic [11:0] tap_mask(input logic [3:0] tap);
      logic [12:0] one;
      one = 13'h0001 << tap;
      return 12'(one - 13'h0001);
   endfunction

   // Word index of a bus byte address
   function automatic logic [15:0] word_idx(input logic [17:0] adr);
      return adr[17:2];
   endfunction

   // ==========================================================
   // State
   wcw_opt_t    opt_q;
   logic        written_q;
   logic        cause_q;
   logic [11:0] presc_q;
   logic [5:0]  ctr_q;
   logic [12:0] por_q;
   logic        por_done_q;
   wcw_stop_t   st_q;
   wcw_stop_t   st_d;
   logic [12:0] rec_q;
   logic [12:0] rec_d;
   logic [5:0]  pulse_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic [2:0]  s1_q;
   logic [2:0]  s2_q;
   logic [2:0]  s3_q;
   logic [2:0]  pin_q;
   logic        ill_q;
   logic        stop_q;
   logic        rstn_q;
   wcw_opt_t    opt_out_q;
   wcw_ctl_t    ctl_q;

   // ==========================================================
   // Bus decode
   wire         bus_req  = WB_CYC_I & WB_STB_I;
   wire         bus_take = bus_req & ack_q;
   wire         bus_wr   = bus_take & WB_WE_I & WB_SEL_I[0];
   wire [15:0]  idx      = word_idx(WB_ADR_I);
   wire         hit_opt  = idx == `WCW_OPT_IDX;
   wire         hit_svc  = idx == `WCW_SVC_IDX;
   wire         hit_stat = idx == `WCW_STAT_IDX;
   wire         opt_wr   = bus_wr & hit_opt;
   wire         svc_wr   = bus_wr & hit_svc;
   wire         stat_wr  = bus_wr & hit_stat;
   wire         opt_load = opt_wr & ~written_q & ~INT_RST_I;

   // Status word
   wire [7:0]   stat_byte = {4'h0, st_q == WCW_RECOVER, st_q == WCW_STOP,
                             cause_q, written_q};

   // Read mux, unmapped reads give zero
   wire [7:0]   rd_byte = hit_opt  ? opt_q :
                          hit_svc  ? `WCW_VEC_LO :
                          hit_stat ? stat_byte : 8'h00;

   // ==========================================================
   // Pin conditioning
   wire         ext_rst_n = pin_q[2];
   wire         tst_irq   = pin_q[1];
   wire         tst_rst   = pin_q[0];
   wire [2:0]   pin_d     = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

   // ==========================================================
   // Watchdog datapath
   wire         stopped  = st_q != WCW_RUN;
   wire         wdog_off = opt_q.wdog_disable |
                           (MON_MODE_I & (tst_irq | tst_rst)) |
                           (BREAK_I & tst_rst);
   wire [3:0]   tap      = opt_q.wdog_rate_sel ? `WCW_TAP_SHORT
                                               : 4'(LONG_TAP);
   wire         ctr_tick = ((presc_q | ~tap_mask(tap)) == 12'hFFF) &
                           ~stopped;
   wire         timeout  = ctr_tick & (ctr_q == 6'h3F) & ~wdog_off &
                           (pulse_q == 6'h00);
   wire         stop_go  = STOP_REQ_I & (st_q == WCW_RUN) &
                           opt_q.stop_en;
   wire         stop_bad = STOP_REQ_I & (st_q == WCW_RUN) &
                           ~opt_q.stop_en;
   wire         por_hit  = ~por_done_q & (por_q == `WCW_POR_CLR);
   wire         presc_clr = INT_RST_I | stop_go | VEC_FETCH_I |
                            por_hit | timeout;
   wire [11:0]  presc_d  = presc_clr ? 12'h000 :
                           svc_wr    ? (presc_q & 12'h00F) :
                           stopped   ? presc_q :
                           12'(presc_q + 12'h001);
   wire [5:0]   ctr_d    = (INT_RST_I | svc_wr | timeout) ? 6'h00 :
                           ctr_tick ? 6'(ctr_q + 6'h01) : ctr_q;
   wire [5:0]   pulse_d  = timeout ? 6'(`WCW_RST_PULSE) :
                           (pulse_q != 6'h00) ? 6'(pulse_q - 6'h01)
                                              : 6'h00;

   // ==========================================================
   // Stop sequencer
   always_comb begin
      st_d  = st_q;
      rec_d = rec_q;
      unique case (st_q)
         WCW_RUN: begin
            if (stop_go) begin
               st_d = WCW_STOP;
            end
         end
         WCW_STOP: begin
            if (~ext_rst_n) begin
               st_d  = WCW_RECOVER;
               rec_d = 13'(`WCW_REC_LONG);
            end else if (WAKE_I) begin
               st_d  = WCW_RECOVER;
               rec_d = opt_q.short_recovery_sel ? 13'(`WCW_REC_SHORT)
                                                : 13'(`WCW_REC_LONG);
            end
         end
         WCW_RECOVER: begin
            rec_d = 13'(rec_q - 13'h0001);
            if (rec_q == 13'h0001) begin
               st_d = WCW_RUN;
            end
         end
         default: begin
            st_d = WCW_RUN;
         end
      endcase
      if (INT_RST_I) begin
         st_d  = WCW_RUN;
         rec_d = 13'h0000;
      end
   end

   // ==========================================================
   // Output values before their flops
   wire         lvi_pwr_d = opt_q.lowv_power_en &
                            (~stopped | opt_q.lowv_in_stop_en);
   wcw_ctl_t    ctl_d;
   assign ctl_d.lvi_power    = lvi_pwr_d;
   assign ctl_d.lvi_reset_en = opt_q.lowv_reset_en;
   assign ctl_d.slow_crystal = opt_q.slow_crystal_sel;

   // ==========================================================
   // Option latches and status
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         opt_q     <= wcw_opt_t'(`WCW_OPT_RST);
         written_q <= 1'b0;
      end else if (INT_RST_I) begin
         opt_q     <= wcw_opt_t'(`WCW_OPT_RST);
         written_q <= 1'b0;
      end else if (opt_load) begin
         opt_q     <= wcw_opt_t'(WB_DAT_I[7:0]);
         written_q <= 1'b1;
      end
   end

   // Cause flag, a new timeout wins over a clear
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cause_q <= 1'b0;
      end else if (timeout) begin
         cause_q <= 1'b1;
      end else if (stat_wr & WB_DAT_I[`WCW_ST_CAUSE]) begin
         cause_q <= 1'b0;
      end
   end

   // ==========================================================
   // Watchdog counters
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         presc_q <= 12'h000;
         ctr_q   <= 6'h00;
         pulse_q <= 6'h00;
      end else begin
         presc_q <= presc_d;
         ctr_q   <= ctr_d;
         pulse_q <= pulse_d;
      end
   end

   // Power-up delay before the prescaler clear
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         por_q      <= 13'h0000;
         por_done_q <= 1'b0;
      end else if (~por_done_q) begin
         por_q      <= 13'(por_q + 13'h0001);
         por_done_q <= por_hit;
      end
   end

   // Stop sequencer state
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q  <= WCW_RUN;
         rec_q <= 13'h0000;
      end else begin
         st_q  <= st_d;
         rec_q <= rec_d;
      end
   end

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s1_q  <= 3'b100;
         s2_q  <= 3'b100;
         s3_q  <= 3'b100;
         pin_q <= 3'b100;
      end else begin
         s1_q  <= {EXT_RST_N_I, TST_IRQ_I, TST_RST_I};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= pin_d;
      end
   end

   // ==========================================================
   // Wishbone answer, one wait state
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= bus_req & ~ack_q;
         rdat_q <= {24'h00_0000, rd_byte};
      end
   end

   // ==========================================================
   // Output flops
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ill_q     <= 1'b0;
         stop_q    <= 1'b0;
         rstn_q    <= 1'b1;
         opt_out_q <= wcw_opt_t'(`WCW_OPT_RST);
         ctl_q     <= wcw_ctl_t'(3'b000);
      end else begin
         ill_q     <= stop_bad;
         stop_q    <= st_d != WCW_RUN;
         rstn_q    <= pulse_d == 6'h00;
         opt_out_q <= opt_q;
         ctl_q     <= ctl_d;
      end
   end

   assign WB_ACK_O       = ack_q;
   assign WB_DAT_O       = rdat_q;
   assign OPT_O          = opt_out_q;
   assign CTL_O          = ctl_q;
   assign STOP_O         = stop_q;
   assign ILLEGAL_OP_O   = ill_q;
   assign WDOG_RST_N_O   = rstn_q;
   assign RST_PIN_OE_N_O = rstn_q;

   // ==========================================================
   // Checks
   sequence short_wake_s;
      (st_q == WCW_STOP) && WAKE_I && ext_rst_n && !INT_RST_I &&
      opt_q.short_recovery_sel;
   endsequence

   sequence short_recover_s;
      (st_q == WCW_RECOVER) [*8] ##24 (st_q == WCW_RECOVER)
      ##1 (st_q == WCW_RUN);
   endsequence

   property first_write_p;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      opt_wr && !written_q && !INT_RST_I |=>
         written_q && (opt_q == $past(WB_DAT_I[7:0]));
   endproperty

   opt_first_a: assert property (first_write_p)
      else $error("first option write not latched");

   opt_once_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      opt_wr && written_q && !INT_RST_I |=> $stable(opt_q))
      else $error("option register changed by a second write");

   rec_short_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      short_wake_s |=> short_recover_s)
      else $error("short stop recovery not 32 cycles");

   rec_pin_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (st_q == WCW_STOP) && !ext_rst_n && !INT_RST_I |=>
         rec_q == `WCW_REC_LONG)
      else $error("reset pin exit did not use long recovery");

   rst_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      timeout |=> !WDOG_RST_N_O && cause_q ##31 !WDOG_RST_N_O
         ##1 WDOG_RST_N_O)
      else $error("watchdog reset pulse not 32 cycles");

   svc_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      svc_wr && !timeout |=> (ctr_q == 6'h00) &&
         (presc_q[11:4] == 8'h00))
      else $error("service write did not clear watchdog");

   stop_ill_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      STOP_REQ_I && (st_q == WCW_RUN) && !opt_q.stop_en |=>
         ILLEGAL_OP_O && !STOP_O)
      else $error("disabled stop not flagged illegal");

   stop_halt_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      stop_go && !INT_RST_I |=> (presc_q == 12'h000) ##1
         ($stable(presc_q) && $stable(ctr_q)))
      else $error("watchdog counted in stop mode");

   wd_off_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (opt_q.wdog_disable || (MON_MODE_I && (tst_irq || tst_rst)) ||
       (BREAK_I && tst_rst)) |-> !timeout)
      else $error("disabled watchdog fired");

   int_rst_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      INT_RST_I |=> (presc_q == 12'h000) && (ctr_q == 6'h00) &&
         !written_q)
      else $error("internal reset did not clear watchdog");

   vec_clr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      VEC_FETCH_I |=> presc_q == 12'h000)
      else $error("vector fetch did not clear prescaler");

   por_clr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(por_done_q) |-> presc_q == 12'h000)
      else $error("power-up prescaler clear missing");

   ack_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      bus_req && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("bus answer not a single cycle");

endmodule
`default_nettype wire

/* wcw_cfg.svh */
// Behaviour
// - Option register takes one write per reset; reset loads its defaults.
// - Option register answers at its fixed address 0x1F.
// - Stop exit delay is 32 cycles with short recovery, else 4096.
// - Leaving stop through the reset pin always uses the long delay.
// - Rate option picks 2^13-2^4 or 2^18-2^4 cycles; reset clears it.
// - Stop with stop-enable clear is an illegal opcode; set, it stops.
// - Watchdog-disable option set turns the watchdog off.
// - Low-voltage power option powers the unit; reset option gates resets.
// - With power on, in-stop option keeps the unit running in stop.
// - Slow-crystal option tells the clock generator to expect slow crystal.
// - Watchdog is 6-bit counter after 12-bit prescaler; overflow resets.
// - Reading the service address returns the reset vector low byte.
// - Timeout drives reset pin low 32 cycles and sets the cause flag.
// - Stop instruction clears prescaler; stop mode halts counting.
// - Power-on logic clears the prescaler 4096 cycles after power-up.
// - Internal reset clears prescaler, counter; vector fetch, prescaler.
// - Monitor mode with test voltage on either pin, or break with it on the reset pin, disables it.
// - Watchdog counts in wait mode and never requests an interrupt.
`ifndef WCW_CFG_SVH
`define WCW_CFG_SVH
// ==========================================================
// Register indices, byte address is four times the index
`define WCW_OPT_IDX      16'h001F
`define WCW_SVC_IDX      16'hFFFF
`define WCW_STAT_IDX     16'h0020
// ==========================================================
// Option reset value, vector low byte and status field positions
`define WCW_OPT_RST      8'h30
`define WCW_VEC_LO       8'h00
`define WCW_ST_WRITTEN   0
`define WCW_ST_CAUSE     1
`define WCW_ST_STOP      2
`define WCW_ST_RECOVER   3
// ==========================================================
// Timing, in oscillator cycles; oscillator is the system clock
`define WCW_OSC_PER_CLK  1
`define WCW_REC_SHORT    (13'd32 / `WCW_OSC_PER_CLK)
`define WCW_REC_LONG     (13'd4096 / `WCW_OSC_PER_CLK)
`define WCW_POR_CLR      (13'd4096 / `WCW_OSC_PER_CLK)
`define WCW_RST_PULSE    (6'd32 / `WCW_OSC_PER_CLK)
`define WCW_TAP_SHORT    4'd7
`define WCW_TAP_LONG     12
`endif

/* wcw_pkg.sv */
// ==========================================================
// Types shared by the option and watchdog block
package wcw_pkg;
   // Option latches, most significant field first
   typedef struct packed {
      logic slow_crystal_sel;
      logic lowv_in_stop_en;
      logic lowv_reset_en;
      logic lowv_power_en;
      logic wdog_rate_sel;
      logic short_recovery_sel;
      logic stop_en;
      logic wdog_disable;
   } wcw_opt_t;

   // Controls handed to the low-voltage unit and clock generator
   typedef struct packed {
      logic lvi_power;
      logic lvi_reset_en;
      logic slow_crystal;
   } wcw_ctl_t;

   // Stop sequencing, Gray along run, stop, recover
   typedef enum logic [1:0] {
      WCW_RUN     = 2'b00,
      WCW_STOP    = 2'b01,
      WCW_RECOVER = 2'b11
   } wcw_stop_t;
endpackage

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_top;
   import wcw_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic        clk;
   logic        rst_n;
   logic        int_rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [17:0] adr;
   logic [3:0]  sel;
   logic [31:0] dat_w;
   logic [31:0] dat_r;
   logic        ack;
   logic        stop_req;
   logic        wake;
   logic        mon;
   logic        ext_rst_n;
   logic        tst_irq;
   logic        vec_fetch;
   logic        brk;
   logic        tst_rst;
   wcw_opt_t    opt;
   wcw_ctl_t    ctl;
   logic        stop_o;
   logic        ill;
   logic        wd_n;
   logic        oe_n;
   logic [31:0] q;
   int          n_fail;
   int          n_tests;
   int          n_low;
   int          n;

   wcw_top #(.LONG_TAP(8)) wcw_top_i (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .INT_RST_I(int_rst),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .STOP_REQ_I(stop_req), .WAKE_I(wake), .VEC_FETCH_I(vec_fetch),
      .MON_MODE_I(mon), .BREAK_I(brk), .EXT_RST_N_I(ext_rst_n),
      .TST_IRQ_I(tst_irq), .TST_RST_I(tst_rst), .OPT_O(opt), .CTL_O(ctl),
      .STOP_O(stop_o), .ILLEGAL_OP_O(ill), .WDOG_RST_N_O(wd_n),
      .RST_PIN_OE_N_O(oe_n)
   );

   // ==========================================================
   // Clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic final_report();
      if (n_fail == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Wishbone classic single access, holds until ack is sampled
   task automatic wb(input logic w, input logic [17:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
      end
      r = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
      repeat (3) @(posedge clk);
   endtask

   task automatic rd(input logic [17:0] a, output logic [31:0] r);
      wb(1'b0, a, 32'h0000_0000, r);
   endtask

   // Service write to the watchdog address
   task automatic svc();
      wr(18'h3_FFFC, 32'h0000_00A5);
   endtask

   // One-cycle pulse on the stop request
   task automatic stop_pulse();
      @(posedge clk);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      @(posedge clk);
   endtask

   // Runs for c cycles, counting cycles with the reset output low
   task automatic idle(input int c);
      n_low = 0;
      repeat (c) begin
         @(posedge clk);
         if (wd_n !== 1'b1) begin
            n_low++;
         end
      end
   endtask

   // Counts cycles until the stop output falls; the pin is let go at 8
   task automatic stop_len(output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
         if (c == 8) begin
            ext_rst_n <= 1'b1;
         end
      end while (stop_o !== 1'b0 && c < 5000);
   endtask

   // Hang guard, 95k cycles against roughly 84k for the tests
   initial begin
      #950_000;
      n_fail++;
      final_report();
   end

   // ==========================================================
   // Main sequence
   initial begin
      n_fail = 0;
      n_tests = 0;
      rst_n = 1'b0;
      int_rst = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 18'h0_0000;
      sel = 4'hF;
      dat_w = 32'h0000_0000;
      stop_req = 1'b0;
      wake = 1'b0;
      mon = 1'b0;
      ext_rst_n = 1'b1;
      tst_irq = 1'b0;
      vec_fetch = 1'b0;
      brk = 1'b0;
      tst_rst = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(opt, 8'h30)
      `CHK(ctl, 3'b110)
      `CHK(wd_n, 1'b1)
      rd(18'h0_007C, q);
      `CHK(q, 32'h0000_0030)
      rd(18'h3_FFFC, q);
      `CHK(q, 32'h0000_0000)
      rd(18'h0_0100, q);
      `CHK(q, 32'h0000_0000)
      // Stop with stop disabled is refused
      stop_pulse();
      `CHK(ill, 1'b1)
      `CHK(stop_o, 1'b0)
      // First write lands, second is ignored
      // Bench clock stands for an external square wave, short recovery ok
      wr(18'h0_007C, 32'h0000_001E);
      `CHK(opt, 8'h1E)
      `CHK(ctl, 3'b100)
      wr(18'h0_007C, 32'h0000_00FF);
      `CHK(opt, 8'h1E)
      // Short recovery stop and wake
      svc();
      stop_pulse();
      repeat (2) @(posedge clk);
      `CHK(stop_o, 1'b1)
      `CHK(ctl.lvi_power, 1'b0)
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      stop_len(n);
      `CHK((n >= 28 && n <= 36), 1'b1)
      // Reset pin exit takes the long delay despite short recovery
      stop_pulse();
      @(posedge clk);
      ext_rst_n <= 1'b0;
      stop_len(n);
      `CHK((n >= 4096 && n <= 4112), 1'b1)
      // Fast rate timeout and reset pulse
      svc();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wd_n !== 1'b0 && n < 9000);
      `CHK((n >= 8160 && n <= 8200), 1'b1)
      `CHK(oe_n, 1'b0)
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wd_n !== 1'b1 && n < 100);
      `CHK(n, 32)
      rd(18'h0_0080, q);
      `CHK(q[1], 1'b1)
      wr(18'h0_0080, 32'h0000_0002);
      rd(18'h0_0080, q);
      `CHK(q[1], 1'b0)
      // Regular servicing keeps the reset away
      svc();
      for (int i = 0; i < 4; i++) begin
         idle(6000);
         `CHK(n_low, 0)
         svc();
      end
      // Internal reset restores defaults and reopens the write
      @(posedge clk);
      int_rst <= 1'b1;
      @(posedge clk);
      int_rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(opt, 8'h30)
      wr(18'h0_007C, 32'h0000_0081);
      `CHK(ctl.slow_crystal, 1'b1)
      idle(20000);
      `CHK(n_low, 0)
      @(posedge clk);
      int_rst <= 1'b1;
      @(posedge clk);
      int_rst <= 1'b0;
      vec_fetch <= 1'b1;
      @(posedge clk);
      vec_fetch <= 1'b0;
      wr(18'h0_007C, 32'h0000_0008);
      `CHK(ctl, 3'b000)
      // Monitor mode with test voltage holds the watchdog off
      mon <= 1'b1;
      tst_irq <= 1'b1;
      idle(9000);
      `CHK(n_low, 0)
      tst_irq <= 1'b0;
      idle(9000);
      `CHK((n_low > 0), 1'b1)
      // Break with test voltage on the reset pin holds the watchdog off
      mon     <= 1'b0;
      brk     <= 1'b1;
      tst_rst <= 1'b1;
      svc();
      repeat (40) @(posedge clk);
      idle(9000);
      `CHK(n_low, 0)
      final_report();
   end
endmodule
`default_nettype wire
